// file: rtl/awd_params.svh
`ifndef AWD_PARAMS_SVH
`define AWD_PARAMS_SVH

// bus geometry
`define AWD_ADDR_W        12
`define AWD_DATA_W        32

// register indexes; byte address is four times the index
`define AWD_IDX_ABOVE_LO  10'h0c4
`define AWD_IDX_ABOVE_HI  10'h0c5
`define AWD_IDX_BELOW_LO  10'h0c6
`define AWD_IDX_BELOW_HI  10'h0c7
`define AWD_IDX_CTRL      10'h0c0
`define AWD_IDX_STATUS    10'h0c1
`define AWD_IDX_MASK      10'h0c2
`define AWD_IDX_RESULT    10'h0c3

// reset values
`define AWD_RST_ABOVE_LO  8'hff
`define AWD_RST_ABOVE_HI  8'hff
`define AWD_RST_BELOW_LO  8'h00
`define AWD_RST_BELOW_HI  8'h00
`define AWD_RST_CTRL      8'h00
`define AWD_RST_STATUS    2'h0
`define AWD_RST_MASK      2'h0

// field positions
`define AWD_CTRL_LJST     0
`define AWD_ST_WIN        0
`define AWD_ST_DONE       1
`define AWD_ST_W          2

// bus responses
`define AWD_RESP_OKAY     2'h0
`define AWD_RESP_SLVERR   2'h2

`endif

// file: rtl/awd_pkg.sv
package awd_pkg;

	// one finished conversion from the converter core
	typedef struct packed {
		logic [11:0] raw;
		logic        differential;
	} awd_conv_t;

	// formatted result word with its interpretation
	typedef struct packed {
		logic [15:0] word;
		logic        signed_cmp;
	} awd_word_t;

	typedef enum logic [0:0] {
		AWD_W_COLLECT,
		AWD_W_RESP
	} awd_wstate_t;

endpackage

// file: rtl/awd_format.sv
`timescale 1ns/100ps

module awd_format (
	input  awd_pkg::awd_conv_t conv,
	input  wire logic          left_justify_select,
	output awd_pkg::awd_word_t formatted
);

	logic [3:0] fill;

	// sign copies only make sense for two's-complement data
	assign fill = conv.differential ? {4{conv.raw[11]}} : 4'h0;

	always_comb begin
		if (left_justify_select) begin
			formatted.word = {conv.raw, 4'h0};
		end else begin
			formatted.word = {fill, conv.raw};
		end
		formatted.signed_cmp = conv.differential;
	end

endmodule

// file: rtl/awd_top.sv
`timescale 1ns/100ps
`include "awd_params.svh"

module awd_top (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [`AWD_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [`AWD_DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`AWD_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]               s_axi_arprot,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [`AWD_DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     conv_done,
	input  awd_pkg::awd_conv_t            conv,
	output logic                          window_hit_flag,
	output logic [15:0]                   result_word,
	output logic                          irq
);

	awd_pkg::awd_wstate_t     wstate_reg;
	logic                     aw_have_reg;
	logic                     w_have_reg;
	logic [9:0]               aw_idx_reg;
	logic [7:0]               w_byte_reg;
	logic                     w_lane_reg;
	logic [1:0]               bresp_reg;
	logic                     rvalid_reg;
	logic [`AWD_DATA_W-1:0]   rdata_reg;
	logic [1:0]               rresp_reg;
	logic                     do_write;
	logic                     wr_en;
	logic [7:0]               above_lo_reg;
	logic [7:0]               above_hi_reg;
	logic [7:0]               below_lo_reg;
	logic [7:0]               below_hi_reg;
	logic [7:0]               ctrl_reg;
	logic [`AWD_ST_W-1:0]     status_reg;
	logic [`AWD_ST_W-1:0]     status_next;
	logic [`AWD_ST_W-1:0]     mask_reg;
	logic [`AWD_ST_W-1:0]     events;
	logic [`AWD_ST_W-1:0]     clear_bits;
	logic [15:0]              result_reg;
	logic [15:0]              above_word;
	logic [15:0]              below_word;
	awd_pkg::awd_word_t       formatted;
	logic signed [16:0]       res_x;
	logic signed [16:0]       above_x;
	logic signed [16:0]       below_x;
	logic                     inside_mode;
	logic                     hit;
	logic [9:0]               ar_idx;
	logic                     ar_take;
	logic                     ar_mapped;
	logic [`AWD_DATA_W-1:0]   ar_data;
	logic                     wr_mapped;

	// result formatting, shared with nothing else
	awd_format u_format (
		.conv                (conv),
		.left_justify_select (ctrl_reg[`AWD_CTRL_LJST]),
		.formatted           (formatted)
	);

	// limit words
	assign above_word = {above_hi_reg, above_lo_reg};
	assign below_word = {below_hi_reg, below_lo_reg};

	// a 17-bit signed compare covers both the signed and unsigned cases
	always_comb begin
		res_x   = {formatted.signed_cmp & formatted.word[15],
			formatted.word};
		above_x = {formatted.signed_cmp & above_word[15],
			above_word};
		below_x = {formatted.signed_cmp & below_word[15],
			below_word};
	end

	assign inside_mode = below_x > above_x;

	always_comb begin
		if (inside_mode) begin
			hit = (res_x < below_x) && (res_x > above_x);
		end else begin
			hit = (res_x < below_x) || (res_x > above_x);
		end
	end

	// events only on the conversion's own cycle
	assign events[`AWD_ST_WIN]  = conv_done & hit;
	assign events[`AWD_ST_DONE] = conv_done;

	// result word as last written by the converter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_reg <= 16'h0000;
		end else if (conv_done) begin
			result_reg <= formatted.word;
		end
	end

	assign result_word = result_reg;

	// write channel: address and data taken in either order
	assign s_axi_awready = (wstate_reg == awd_pkg::AWD_W_COLLECT) &&
		!aw_have_reg;
	assign s_axi_wready  = (wstate_reg == awd_pkg::AWD_W_COLLECT) &&
		!w_have_reg;
	assign do_write      = (wstate_reg == awd_pkg::AWD_W_COLLECT) &&
		aw_have_reg && w_have_reg;
	assign wr_en         = do_write && w_lane_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_idx_reg  <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_idx_reg  <= s_axi_awaddr[`AWD_ADDR_W-1:2];
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_reg <= 1'b0;
			w_byte_reg <= 8'h00;
			w_lane_reg <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_byte_reg <= s_axi_wdata[7:0];
			w_lane_reg <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end
	end

	always_comb begin
		case (aw_idx_reg)
			`AWD_IDX_ABOVE_LO,
			`AWD_IDX_ABOVE_HI,
			`AWD_IDX_BELOW_LO,
			`AWD_IDX_BELOW_HI,
			`AWD_IDX_CTRL,
			`AWD_IDX_STATUS,
			`AWD_IDX_MASK,
			`AWD_IDX_RESULT: begin
				wr_mapped = 1'b1;
			end
			default: begin
				wr_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate_reg <= awd_pkg::AWD_W_COLLECT;
			bresp_reg  <= `AWD_RESP_OKAY;
		end else begin
			case (wstate_reg)
				awd_pkg::AWD_W_COLLECT: begin
					if (do_write) begin
						wstate_reg <= awd_pkg::AWD_W_RESP;
						bresp_reg  <= wr_mapped ? `AWD_RESP_OKAY :
							`AWD_RESP_SLVERR;
					end
				end
				awd_pkg::AWD_W_RESP: begin
					if (s_axi_bready) begin
						wstate_reg <= awd_pkg::AWD_W_COLLECT;
					end
				end
				default: begin
					wstate_reg <= awd_pkg::AWD_W_COLLECT;
				end
			endcase
		end
	end

	assign s_axi_bvalid = (wstate_reg == awd_pkg::AWD_W_RESP);
	assign s_axi_bresp  = bresp_reg;

	// limit and control registers; lane 0 carries all byte-wide fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			above_lo_reg <= `AWD_RST_ABOVE_LO;
			above_hi_reg <= `AWD_RST_ABOVE_HI;
			below_lo_reg <= `AWD_RST_BELOW_LO;
			below_hi_reg <= `AWD_RST_BELOW_HI;
		end else if (wr_en) begin
			if (aw_idx_reg == `AWD_IDX_ABOVE_LO) begin
				above_lo_reg <= w_byte_reg;
			end
			if (aw_idx_reg == `AWD_IDX_ABOVE_HI) begin
				above_hi_reg <= w_byte_reg;
			end
			if (aw_idx_reg == `AWD_IDX_BELOW_LO) begin
				below_lo_reg <= w_byte_reg;
			end
			if (aw_idx_reg == `AWD_IDX_BELOW_HI) begin
				below_hi_reg <= w_byte_reg;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `AWD_RST_CTRL;
		end else if (wr_en && aw_idx_reg == `AWD_IDX_CTRL) begin
			ctrl_reg <= {7'h00, w_byte_reg[`AWD_CTRL_LJST]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_reg <= `AWD_RST_MASK;
		end else if (wr_en && aw_idx_reg == `AWD_IDX_MASK) begin
			mask_reg <= w_byte_reg[`AWD_ST_W-1:0];
		end
	end

	// sticky status; a new event beats a same-cycle write of one
	assign clear_bits = (wr_en && aw_idx_reg == `AWD_IDX_STATUS) ?
		w_byte_reg[`AWD_ST_W-1:0] : {`AWD_ST_W{1'b0}};

	assign status_next = (status_reg & ~clear_bits) | events;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= `AWD_RST_STATUS;
		end else begin
			status_reg <= status_next;
		end
	end

	assign window_hit_flag = status_reg[`AWD_ST_WIN];
	assign irq             = |(status_reg & mask_reg);

	// read channel: one cycle from address to data
	assign s_axi_arready = !rvalid_reg;
	assign ar_take       = s_axi_arvalid && s_axi_arready;
	assign ar_idx        = s_axi_araddr[`AWD_ADDR_W-1:2];

	always_comb begin
		ar_mapped = 1'b1;
		ar_data   = 32'h0000_0000;
		case (ar_idx)
			`AWD_IDX_ABOVE_LO: begin
				ar_data[7:0] = above_lo_reg;
			end
			`AWD_IDX_ABOVE_HI: begin
				ar_data[7:0] = above_hi_reg;
			end
			`AWD_IDX_BELOW_LO: begin
				ar_data[7:0] = below_lo_reg;
			end
			`AWD_IDX_BELOW_HI: begin
				ar_data[7:0] = below_hi_reg;
			end
			`AWD_IDX_CTRL: begin
				ar_data[7:0] = ctrl_reg;
			end
			`AWD_IDX_STATUS: begin
				ar_data[`AWD_ST_W-1:0] = status_reg;
			end
			`AWD_IDX_MASK: begin
				ar_data[`AWD_ST_W-1:0] = mask_reg;
			end
			`AWD_IDX_RESULT: begin
				ar_data[15:0] = result_reg;
			end
			default: begin
				ar_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= `AWD_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= ar_data;
			rresp_reg  <= ar_mapped ? `AWD_RESP_OKAY : `AWD_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// checks next to the logic they guard
	a_flag_sets_on_hit: assert property (
		@(posedge aclk) disable iff (!aresetn)
		conv_done && hit |=> window_hit_flag)
		else $error("window hit did not set the flag");

	a_flag_sticky: assert property (
		@(posedge aclk) disable iff (!aresetn)
		window_hit_flag && !(wr_en && aw_idx_reg == `AWD_IDX_STATUS &&
		w_byte_reg[`AWD_ST_WIN]) |=> window_hit_flag)
		else $error("window flag dropped without a clear");

	a_flag_no_cause: assert property (
		@(posedge aclk) disable iff (!aresetn)
		!window_hit_flag && !(conv_done && hit) |=> !window_hit_flag)
		else $error("window flag rose without a hit");

	a_inside_window: assert property (
		@(posedge aclk) disable iff (!aresetn)
		conv_done && inside_mode && (res_x >= below_x) |->
		!events[`AWD_ST_WIN])
		else $error("inside window hit above the upper limit");

	a_outside_window: assert property (
		@(posedge aclk) disable iff (!aresetn)
		conv_done && !inside_mode && (res_x > above_x) |->
		events[`AWD_ST_WIN])
		else $error("outside window missed a high result");

	a_signed_compare: assert property (
		@(posedge aclk) disable iff (!aresetn)
		conv_done && conv.differential && below_word == 16'hffff &&
		above_word == 16'h0100 && formatted.word[15] &&
		formatted.word != 16'hffff |-> events[`AWD_ST_WIN])
		else $error("negative result not below minus one");

	a_irq_follows: assert property (
		@(posedge aclk) disable iff (!aresetn)
		window_hit_flag && mask_reg[`AWD_ST_WIN] |-> irq)
		else $error("enabled window flag gave no interrupt");

	a_result_format: assert property (
		@(posedge aclk) disable iff (!aresetn)
		conv_done && !ctrl_reg[`AWD_CTRL_LJST] |=>
		result_reg[15:12] == ($past(conv.differential) ?
		{4{$past(conv.raw[11])}} : 4'h0))
		else $error("right justified fill bits wrong");

	a_left_justify: assert property (
		@(posedge aclk) disable iff (!aresetn)
		conv_done && ctrl_reg[`AWD_CTRL_LJST] |=>
		result_reg == {$past(conv.raw), 4'h0})
		else $error("left justified result wrong");

	a_read_latency: assert property (
		@(posedge aclk) disable iff (!aresetn)
		ar_take |=> s_axi_rvalid ##0 s_axi_rdata == $past(ar_data))
		else $error("read answer not one cycle after address");

endmodule

// file: verification/awd_conv_model.sv
`timescale 1ns/100ps

// converter core stand-in; lat sets how slowly each result arrives
module awd_conv_model (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          start,
	input  wire logic [11:0]   raw,
	input  wire logic          diff,
	input  wire logic [3:0]    lat,
	output logic               conv_done,
	output awd_pkg::awd_conv_t conv
);
	logic               busy_reg;
	logic [3:0]         cnt_reg;
	awd_pkg::awd_conv_t hold_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg  <= 1'b0;
			cnt_reg   <= 4'h0;
			hold_reg  <= '0;
			conv_done <= 1'b0;
			conv      <= '0;
		end else begin
			conv_done <= 1'b0;
			// scrambled outside the done cycle so stale data never passes
			conv      <= ~conv;
			if (busy_reg && cnt_reg == 4'h0) begin
				busy_reg  <= 1'b0;
				conv_done <= 1'b1;
				conv      <= hold_reg;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end else if (start) begin
				busy_reg <= 1'b1;
				cnt_reg  <= lat;
				hold_reg <= {raw, diff};
			end
		end
	end
endmodule

// file: verification/awd_top_tb.sv
`timescale 1ns/100ps
`include "awd_params.svh"

module awd_top_tb;
	logic               aclk = 1'b0;
	logic               aresetn = 1'b0;
	logic [11:0]        s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0]        s_axi_wdata = 32'h0;
	logic [3:0]         s_axi_wstrb = 4'h0;
	logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic               s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic               s_axi_rready = 1'b0, start = 1'b0, diff = 1'b0;
	logic [11:0]        raw = 12'h0;
	logic [3:0]         lat = 4'h0;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic               s_axi_arready, s_axi_rvalid, conv_done;
	logic               window_hit_flag, irq;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic [31:0]        s_axi_rdata;
	logic [15:0]        result_word;
	awd_pkg::awd_conv_t conv;
	int                 mismatches = 0;
	int                 check_count = 0;

	always #5 aclk = ~aclk;

	awd_top u_dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .conv_done, .conv,
		.window_hit_flag, .result_word, .irq
	);

	awd_conv_model u_conv (
		.aclk, .aresetn, .start, .raw, .diff, .lat, .conv_done, .conv
	);

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic cb(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask

	task automatic hang;
		mismatches++;
		$display("[FAIL] %0t wait ran out", $time);
		end_of_test;
	endtask

	// address and data are offered together, released as each is taken
	task automatic wr(input logic [9:0] i, input logic [7:0] d,
			input logic [3:0] s, output logic [1:0] r);
		bit a, w, b;
		@(posedge aclk);
		s_axi_awaddr  <= {i, 2'b00};
		s_axi_wdata   <= {24'h0, d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge aclk);
			a = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) begin
				s_axi_bready <= 1'b0;
				@(negedge aclk);
				return;
			end
		end
		hang;
	endtask

	task automatic rd(input logic [9:0] i, output logic [31:0] d,
			output logic [1:0] r);
		bit a, v;
		@(posedge aclk);
		s_axi_araddr  <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(negedge aclk);
			a = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (a) s_axi_arvalid <= 1'b0;
			if (v) begin
				s_axi_rready <= 1'b0;
				// let the handshake edge settle before callers sample
				@(negedge aclk);
				return;
			end
		end
		hang;
	endtask

	task automatic w8(input logic [9:0] i, input logic [7:0] d);
		logic [1:0] r;
		wr(i, d, 4'hf, r);
		chk({30'h0, r}, {30'h0, `AWD_RESP_OKAY});
	endtask

	task automatic rchk(input logic [9:0] i, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(i, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, `AWD_RESP_OKAY});
	endtask

	task automatic cvt(input logic [11:0] v, input logic dm);
		@(posedge aclk);
		raw   <= v;
		diff  <= dm;
		start <= 1'b1;
		@(posedge aclk);
		start <= 1'b0;
		for (int n = 0; n < 40; n++) begin
			@(negedge aclk);
			if (conv_done) begin
				@(negedge aclk);
				return;
			end
		end
		hang;
	endtask

	task automatic run(input logic [15:0] lt, input logic [15:0] gt,
			input logic lj, input logic dm, input logic [11:0] v,
			input logic hit);
		logic [15:0] f;
		f = lj ? {v, 4'h0} : {(dm ? {4{v[11]}} : 4'h0), v};
		w8(`AWD_IDX_BELOW_LO, lt[7:0]);
		w8(`AWD_IDX_BELOW_HI, lt[15:8]);
		w8(`AWD_IDX_ABOVE_LO, gt[7:0]);
		w8(`AWD_IDX_ABOVE_HI, gt[15:8]);
		w8(`AWD_IDX_CTRL, {7'h0, lj});
		w8(`AWD_IDX_STATUS, 8'h03);
		cvt(v, dm);
		chk({16'h0, result_word}, {16'h0, f});
		cb(window_hit_flag, hit);
		rchk(`AWD_IDX_STATUS, {30'h0, 1'b1, hit});
	endtask

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`AWD_IDX_ABOVE_HI, 32'h0000_00ff);
		rchk(`AWD_IDX_BELOW_LO, 32'h0);
		rchk(`AWD_IDX_BELOW_HI, 32'h0);
		rchk(`AWD_IDX_ABOVE_LO, 32'h0000_00ff);
		rchk(`AWD_IDX_MASK, 32'h0);
		cb(window_hit_flag, 1'b0);
		rd(10'h000, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `AWD_RESP_SLVERR});
		wr(10'h000, 8'h55, 4'hf, r);
		chk({30'h0, r}, {30'h0, `AWD_RESP_SLVERR});
		$display("test reset_and_map done");
		run(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h150, 1'b1);
		run(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h200, 1'b0);
		run(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h100, 1'b0);
		run(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h800, 1'b0);
		lat <= 4'h9;
		run(16'h0100, 16'h0200, 1'b0, 1'b0, 12'h0ff, 1'b1);
		run(16'h0100, 16'h0200, 1'b0, 1'b0, 12'h201, 1'b1);
		run(16'h0100, 16'h0200, 1'b0, 1'b0, 12'h150, 1'b0);
		run(16'h0100, 16'hffff, 1'b0, 1'b1, 12'h000, 1'b1);
		run(16'h0100, 16'hffff, 1'b0, 1'b1, 12'hfff, 1'b0);
		run(16'h0100, 16'hffff, 1'b0, 1'b1, 12'h7ff, 1'b0);
		run(16'hffff, 16'h0100, 1'b0, 1'b1, 12'h800, 1'b1);
		run(16'h2000, 16'h1000, 1'b1, 1'b0, 12'h101, 1'b1);
		run(16'h2000, 16'h1000, 1'b1, 1'b0, 12'h200, 1'b0);
		run(16'h1000, 16'hfff0, 1'b1, 1'b1, 12'h000, 1'b1);
		run(16'hfff0, 16'h1000, 1'b1, 1'b1, 12'h800, 1'b1);
		run(16'hfff0, 16'h1000, 1'b1, 1'b1, 12'hfff, 1'b0);
		$display("test window_compare done");
		lat <= 4'h0;
		run(16'h0200, 16'h0100, 1'b0, 1'b0, 12'h150, 1'b1);
		cvt(12'h050, 1'b0);
		cb(window_hit_flag, 1'b1);
		w8(`AWD_IDX_STATUS, 8'h02);
		cb(window_hit_flag, 1'b1);
		cb(irq, 1'b0);
		w8(`AWD_IDX_MASK, 8'h01);
		cb(irq, 1'b1);
		w8(`AWD_IDX_STATUS, 8'h01);
		cb(window_hit_flag, 1'b0);
		cb(irq, 1'b0);
		cvt(12'h150, 1'b0);
		cb(irq, 1'b1);
		// done bit alone must also reach the interrupt when unmasked
		w8(`AWD_IDX_STATUS, 8'h01);
		w8(`AWD_IDX_MASK, 8'h02);
		cb(irq, 1'b1);
		cb(window_hit_flag, 1'b0);
		w8(`AWD_IDX_MASK, 8'h00);
		cb(irq, 1'b0);
		$display("test sticky_and_irq done");
		w8(`AWD_IDX_ABOVE_LO, 8'h34);
		wr(`AWD_IDX_ABOVE_LO, 8'h12, 4'h0, r);
		chk({30'h0, r}, {30'h0, `AWD_RESP_OKAY});
		rchk(`AWD_IDX_ABOVE_LO, 32'h0000_0034);
		w8(`AWD_IDX_RESULT, 8'hff);
		rchk(`AWD_IDX_RESULT, 32'h0000_0150);
		$display("test access done");
		end_of_test;
	end
endmodule
